// *** design/cdfs_core.sv ***
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module cdfs_core #(
    parameter int NREG = cdfs_pkg::NREG
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Decoder side
    input wire cdfs_pkg::cdfs_op_t op_i,
    input wire logic condition_flag_i,
    input wire logic [31:0] mem_rdata_i,
    output logic [31:0] result_o,
    output cdfs_pkg::cdfs_flags_t flags_o
);
    // ==========================================
    // State
    logic [31:0] dreg_ff [NREG];
    logic [39:0] acc_ff [2];
    logic [31:0] result_ff;
    cdfs_pkg::cdfs_flags_t flags_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;

    // ==========================================
    // Operand fetch and helpers
    logic [31:0] rd0;
    logic [31:0] rd1;
    logic [32:0] add33;
    logic [32:0] sub33;
    logic [16:0] add17;
    logic [16:0] sub17;
    logic signed [16:0] mop0;
    logic signed [16:0] mop1;
    logic signed [33:0] prod34;
    logic [31:0] prod;
    logic [39:0] acc_prod;
    logic [7:0] mem_byte;
    logic [15:0] mem_half;
    logic acc0_fits;
    logic acc1_fits;
    logic wr_stat;

    assign rd0 = dreg_ff[op_i.src0];
    assign rd1 = dreg_ff[op_i.src1];
    assign add33 = {1'b0, rd0} + {1'b0, rd1};
    assign sub33 = {1'b0, rd0} - {1'b0, rd1};
    assign add17 = {1'b0, rd0[15:0]} + {1'b0, rd1[15:0]};
    assign sub17 = {1'b0, rd0[15:0]} - {1'b0, rd1[15:0]};
    // Fractions forced signed; per-operand choice otherwise
    assign mop0 = {(op_i.sgn0 | op_i.frac) & rd0[15], rd0[15:0]};
    assign mop1 = {(op_i.sgn1 | op_i.frac) & rd1[15], rd1[15:0]};
    assign prod34 = mop0 * mop1;
    assign prod = prod34[31:0];
    // Signed product widened, shifted only in fractional mode
    assign acc_prod = op_i.frac ? {{7{prod[31]}}, prod, 1'b0} : {{8{prod[31]}}, prod};
    // Lane zero is the lowest address
    assign mem_byte = mem_rdata_i[8 * op_i.byte_off +: 8];
    assign mem_half = mem_rdata_i[16 * op_i.byte_off[1] +: 16];
    assign acc0_fits = &acc_ff[0][39:31] | ~|acc_ff[0][39:31];
    assign acc1_fits = &acc_ff[1][39:31] | ~|acc_ff[1][39:31];
    assign wr_stat = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & (wb_adr_i == cdfs_pkg::ADDR_STATUS);

    // Redundant sign bits of a two's complement word
    function automatic logic [4:0] cdfs_exp(input logic [31:0] v);
        logic [4:0] n;
        logic run;
        n = 5'h00;
        run = 1'b1;
        for (int i = 30; i >= 0; i--)
        begin
            if (run && v[i] == v[31])
                n = n + 5'h01;
            else
                run = 1'b0;
        end
        return n;
    endfunction : cdfs_exp

    // ==========================================
    // Next-state decode
    logic we0, we1, acc_we, acc_idx;
    logic [2:0] widx0, widx1;
    logic [31:0] wval0, wval1;
    logic [39:0] acc_val;
    logic upd_z, upd_n, upd_c, upd_av, upd_v;
    logic nxt_z, nxt_n, nxt_c, nxt_av, nxt_v;

    always_comb
    begin
        we0 = 1'b0;
        we1 = 1'b0;
        widx0 = op_i.dst;
        widx1 = op_i.src1;
        wval0 = rd0;
        wval1 = acc_ff[1][31:0];
        acc_we = 1'b0;
        acc_idx = op_i.alu1;
        acc_val = acc_ff[op_i.alu1];
        upd_z = 1'b0;
        upd_n = 1'b0;
        upd_c = 1'b0;
        upd_av = 1'b0;
        upd_v = 1'b0;
        nxt_c = 1'b0;
        nxt_av = 1'b0;
        nxt_v = 1'b0;
        if (op_i.valid)
        begin
            unique case (op_i.op)
                cdfs_pkg::CDFS_MOV:
                    we0 = 1'b1;
                cdfs_pkg::CDFS_MOVCC:
                    we0 = condition_flag_i ^ op_i.cc_inv;
                cdfs_pkg::CDFS_EXT_HALF:
                begin
                    we0 = 1'b1;
                    upd_z = 1'b1;
                    wval0 = {{16{op_i.sgn0 & rd0[15]}}, rd0[15:0]};
                end
                cdfs_pkg::CDFS_EXT_BYTE:
                begin
                    we0 = 1'b1;
                    upd_z = 1'b1;
                    wval0 = {{24{op_i.sgn0 & rd0[7]}}, rd0[7:0]};
                end
                cdfs_pkg::CDFS_LOAD:
                begin
                    we0 = 1'b1;
                    // Whole word when fractional
                    if (op_i.frac)
                        wval0 = mem_rdata_i;
                    else if (op_i.half)
                        wval0 = {{16{op_i.sgn0 & mem_half[15]}}, mem_half};
                    else
                        wval0 = {{24{op_i.sgn0 & mem_byte[7]}}, mem_byte};
                end
                cdfs_pkg::CDFS_ADD, cdfs_pkg::CDFS_SUB:
                begin
                    we0 = 1'b1;
                    upd_z = 1'b1;
                    upd_n = 1'b1;
                    upd_c = 1'b1;
                    upd_av = 1'b1;
                    if (op_i.half)
                    begin
                        wval0 = {rd0[31:16],
                            (op_i.op == cdfs_pkg::CDFS_ADD) ? add17[15:0] : sub17[15:0]};
                        nxt_c = (op_i.op == cdfs_pkg::CDFS_ADD) ? add17[16] : ~sub17[16];
                        nxt_av = (op_i.op == cdfs_pkg::CDFS_ADD)
                            ? (rd0[15] == rd1[15]) && (add17[15] != rd0[15])
                            : (rd0[15] != rd1[15]) && (sub17[15] != rd0[15]);
                    end
                    else
                    begin
                        wval0 = (op_i.op == cdfs_pkg::CDFS_ADD) ? add33[31:0] : sub33[31:0];
                        nxt_c = (op_i.op == cdfs_pkg::CDFS_ADD) ? add33[32] : ~sub33[32];
                        nxt_av = (op_i.op == cdfs_pkg::CDFS_ADD)
                            ? (rd0[31] == rd1[31]) && (add33[31] != rd0[31])
                            : (rd0[31] != rd1[31]) && (sub33[31] != rd0[31]);
                    end
                end
                cdfs_pkg::CDFS_AND:
                begin
                    we0 = 1'b1;
                    upd_z = 1'b1;
                    upd_n = 1'b1;
                    wval0 = rd0 & rd1;
                end
                cdfs_pkg::CDFS_DIVSTEP:
                begin
                    we0 = 1'b1;
                    upd_n = 1'b1;
                    wval0 = {rd0[30:0], ~(rd0[31] ^ rd1[31])};
                end
                cdfs_pkg::CDFS_MUL:
                begin
                    acc_we = 1'b1;
                    acc_val = acc_prod;
                    upd_z = 1'b1;
                    upd_n = 1'b1;
                end
                cdfs_pkg::CDFS_ACC_TO_REG:
                begin
                    we0 = 1'b1;
                    upd_z = 1'b1;
                    upd_n = 1'b1;
                    widx0 = {op_i.dst[2:1], op_i.alu1};
                    wval0 = acc_ff[op_i.alu1][31:0];
                end
                cdfs_pkg::CDFS_ACC_PAIR:
                begin
                    we0 = 1'b1;
                    we1 = 1'b1;
                    upd_z = 1'b1;
                    upd_v = 1'b1;
                    widx0 = {op_i.dst[2:1], 1'b0};
                    widx1 = {op_i.src1[2:1], 1'b1};
                    wval0 = acc_ff[0][31:0];
                    nxt_v = ~acc0_fits | ~acc1_fits;
                end
                cdfs_pkg::CDFS_LSHIFT:
                begin
                    we0 = 1'b1;
                    upd_z = 1'b1;
                    wval0 = rd0 >> op_i.shamt;
                end
                cdfs_pkg::CDFS_ASHIFT:
                begin
                    we0 = 1'b1;
                    upd_z = 1'b1;
                    upd_n = 1'b1;
                    wval0 = $signed(rd0) >>> op_i.shamt;
                end
                cdfs_pkg::CDFS_EXP:
                begin
                    we0 = 1'b1;
                    wval0 = {27'h0000000, cdfs_exp(rd0)};
                end
                cdfs_pkg::CDFS_ACC_LO_LD:
                begin
                    acc_we = 1'b1;
                    upd_z = 1'b1;
                    acc_val = {acc_ff[op_i.alu1][39:16], rd0[15:0]};
                end
                cdfs_pkg::CDFS_ACC_HI_LD:
                begin
                    acc_we = 1'b1;
                    acc_val = {acc_ff[op_i.alu1][39:32], rd0[31:16], acc_ff[op_i.alu1][15:0]};
                end
                default:
                    we0 = 1'b0;
            endcase
        end
        nxt_z = acc_we ? (acc_val == 40'h00_0000_0000)
                       : (op_i.half ? wval0[15:0] == 16'h0000 : wval0 == 32'h0000_0000);
        // Sign read from the result MSB
        nxt_n = acc_we ? acc_val[39] : (op_i.half ? wval0[15] : wval0[31]);
        if (we1 && !we0)
            nxt_z = 1'b0;
    end

    // ==========================================
    // Data registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NREG; i++)
                dreg_ff[i] <= cdfs_pkg::DREG_RST;
            result_ff <= cdfs_pkg::RESULT_RST;
        end
        else
        begin
            if (we0)
            begin
                dreg_ff[widx0] <= wval0;
                result_ff <= wval0;
            end
            if (we1)
                dreg_ff[widx1] <= wval1;
        end
    end

    // ==========================================
    // Accumulators
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            acc_ff[0] <= cdfs_pkg::ACC_RST;
            acc_ff[1] <= cdfs_pkg::ACC_RST;
        end
        else if (acc_we)
            acc_ff[acc_idx] <= acc_val;
    end

    // ==========================================
    // Status flags, hardware set beats software write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            flags_ff <= cdfs_pkg::STATUS_RST;
        else
        begin
            if (wr_stat && wb_sel_i[0])
                flags_ff[7:0] <= wb_dat_i[7:0];
            if (wr_stat && wb_sel_i[1])
                flags_ff[9:8] <= wb_dat_i[9:8];
            if (upd_z)
                flags_ff.zero_flag <= nxt_z;
            if (upd_n)
                flags_ff.negative_flag <= nxt_n;
            if (upd_c && !op_i.alu1)
                flags_ff.alu0_carry_flag <= nxt_c;
            if (upd_c && op_i.alu1)
                flags_ff.alu1_carry_flag <= nxt_c;
            if (upd_av && !op_i.alu1)
                flags_ff.alu0_overflow_flag <= nxt_av;
            if (upd_av && op_i.alu1)
                flags_ff.alu1_overflow_flag <= nxt_av;
            if (upd_av && nxt_av && !op_i.alu1)
                flags_ff.alu0_sticky_overflow <= 1'b1;
            if (upd_av && nxt_av && op_i.alu1)
                flags_ff.alu1_sticky_overflow <= 1'b1;
            if (upd_v)
                flags_ff.transfer_overflow_flag <= nxt_v;
            if (upd_v && nxt_v)
                flags_ff.transfer_sticky_overflow <= 1'b1;
        end
    end

    // ==========================================
    // Wishbone slave, one wait state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
            if (wb_adr_i == cdfs_pkg::ADDR_STATUS)
                rdat_ff <= {22'h000000, flags_ff};
            else if (wb_adr_i == cdfs_pkg::ADDR_RESULT)
                rdat_ff <= result_ff;
            else if (wb_adr_i == cdfs_pkg::ADDR_ACC0_X)
                rdat_ff <= {24'h000000, acc_ff[0][39:32]};
            else if (wb_adr_i == cdfs_pkg::ADDR_ACC1_X)
                rdat_ff <= {24'h000000, acc_ff[1][39:32]};
            else if (wb_adr_i[7:5] == cdfs_pkg::ADDR_DREG_BASE[7:5] && wb_adr_i[1:0] == 2'h0)
                rdat_ff <= dreg_ff[wb_adr_i[4:2]];
            else
                rdat_ff <= 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
    assign result_o = result_ff;
    assign flags_o = flags_ff;

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic is_op;
    assign is_op = op_i.valid;

    zext_half_a: assert property (is_op && op_i.op == cdfs_pkg::CDFS_EXT_HALF && !op_i.sgn0
        |=> result_o == {16'h0000, $past(rd0[15:0])}) else $error("half zero fill wrong");
    sext_byte_a: assert property (is_op && op_i.op == cdfs_pkg::CDFS_EXT_BYTE && op_i.sgn0
        |=> result_o == {{24{$past(rd0[7])}}, $past(rd0[7:0])}) else $error("byte sign fill wrong");
    sticky_hold_a: assert property (flags_ff.alu0_sticky_overflow && !wr_stat
        |=> flags_ff.alu0_sticky_overflow) else $error("sticky overflow lost");
    carry_add_a: assert property (is_op && op_i.op == cdfs_pkg::CDFS_ADD && !op_i.half
        && !op_i.alu1
        |=> flags_ff.alu0_carry_flag == $past(add33[32])) else $error("carry wrong");
    ovf_mixed_a: assert property (is_op && op_i.op == cdfs_pkg::CDFS_ADD && !op_i.half
        && !op_i.alu1
        && rd0[31] != rd1[31] |=> !flags_ff.alu0_overflow_flag) else $error("mixed sign overflow");
    frac_mul_a: assert property (is_op && op_i.op == cdfs_pkg::CDFS_MUL && op_i.frac
        && !op_i.alu1
        |=> acc_ff[0] == {{7{$past(prod[31])}}, $past(prod), 1'b0}) else $error("frac product wrong");
    int_mul_a: assert property (is_op && op_i.op == cdfs_pkg::CDFS_MUL && !op_i.frac
        && op_i.alu1
        |=> acc_ff[1] == {{8{$past(prod[31])}}, $past(prod)}) else $error("int product wrong");
    movcc_skip_a: assert property (is_op && op_i.op == cdfs_pkg::CDFS_MOVCC
        && condition_flag_i == op_i.cc_inv |=> $stable(result_o)) else $error("cond move leaked");
    pair_ovf_a: assert property (is_op && op_i.op == cdfs_pkg::CDFS_ACC_PAIR && !acc0_fits
        |=> flags_ff.transfer_overflow_flag && flags_ff.transfer_sticky_overflow)
        else $error("transfer overflow missed");
    ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !ack_ff |=> ack_ff ##1 !ack_ff)
        else $error("ack not one cycle");

    pair_move_c: cover property (is_op && op_i.op == cdfs_pkg::CDFS_ACC_PAIR);
    sticky_clear_c: cover property (flags_ff.alu0_sticky_overflow ##1 !flags_ff.alu0_sticky_overflow);
    frac_mul_c: cover property (is_op && op_i.op == cdfs_pkg::CDFS_MUL && op_i.frac);
endmodule : cdfs_core

// *** design/cdfs_pkg.sv ***
package cdfs_pkg;
    // ==========================================
    // Widths and register map
    localparam int DATA_W = 32;
    localparam int ACC_W = 40;
    localparam int NREG = 8;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_RESULT = 8'h04;
    localparam logic [7:0] ADDR_ACC0_X = 8'h08;
    localparam logic [7:0] ADDR_ACC1_X = 8'h0C;
    localparam logic [7:0] ADDR_DREG_BASE = 8'h20;
    localparam logic [9:0] STATUS_RST = 10'h000;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
    localparam logic [31:0] DREG_RST = 32'h0000_0000;

    // ==========================================
    // Operations from the decoder
    typedef enum logic [4:0] {
        CDFS_NOP = 5'h00, CDFS_MOV = 5'h01, CDFS_MOVCC = 5'h02,
        CDFS_EXT_HALF = 5'h03, CDFS_EXT_BYTE = 5'h04, CDFS_ADD = 5'h05,
        CDFS_SUB = 5'h06, CDFS_AND = 5'h07, CDFS_DIVSTEP = 5'h08,
        CDFS_MUL = 5'h09, CDFS_ACC_TO_REG = 5'h0A, CDFS_ACC_PAIR = 5'h0B,
        CDFS_LSHIFT = 5'h0C, CDFS_ASHIFT = 5'h0D, CDFS_EXP = 5'h0E,
        CDFS_LOAD = 5'h0F, CDFS_ACC_LO_LD = 5'h10, CDFS_ACC_HI_LD = 5'h11
    } cdfs_opcode_t;

    typedef struct packed {
        logic valid;
        cdfs_opcode_t op;
        logic [2:0] dst;
        logic [2:0] src0;
        logic [2:0] src1;
        logic alu1;
        logic half;
        logic frac;
        logic sgn0;
        logic sgn1;
        logic cc_inv;
        logic [4:0] shamt;
        logic [1:0] byte_off;
    } cdfs_op_t;

    typedef struct packed {
        logic transfer_sticky_overflow;
        logic transfer_overflow_flag;
        logic alu1_sticky_overflow;
        logic alu1_overflow_flag;
        logic alu0_sticky_overflow;
        logic alu0_overflow_flag;
        logic alu1_carry_flag;
        logic alu0_carry_flag;
        logic negative_flag;
        logic zero_flag;
    } cdfs_flags_t;
endpackage : cdfs_pkg

// *** verif/cdfs_dec_model.sv ***
`timescale 1ns/100ps
module cdfs_dec_model (
    // Clock
    input wire logic clk_i,
    // Operation port
    output cdfs_pkg::cdfs_op_t op_o,
    output logic cc_o,
    output logic [31:0] mem_o
);
    // ==========================================
    // Idle state
    initial
    begin
        op_o = '0;
        cc_o = 1'b0;
        mem_o = 32'h0000_0000;
    end

    // ==========================================
    // One operation, then idle
    task automatic issue(input cdfs_pkg::cdfs_opcode_t code, input logic [11:0] r,
        input logic [4:0] mode, input logic [31:0] mem = 32'h0000_0000,
        input logic cc = 1'b0, input logic inv = 1'b0);
        cdfs_pkg::cdfs_op_t o;
        o = '0;
        o.valid = 1'b1;
        o.op = code;
        o.dst = r[10:8];
        o.src0 = r[6:4];
        o.src1 = r[2:0];
        {o.alu1, o.half, o.frac, o.sgn0, o.sgn1} = mode;
        o.cc_inv = inv;
        o.byte_off = 2'h2;
        @(posedge clk_i);
        op_o <= o;
        cc_o <= cc;
        mem_o <= mem;
        @(posedge clk_i);
        op_o.valid <= 1'b0;
        cc_o <= ~cc;
        mem_o <= ~mem;
        #1;
    endtask : issue
endmodule : cdfs_dec_model

// *** verif/test_core_data_format_and_status.sv ***
`timescale 1ns/100ps
module test_core_data_format_and_status;
    // ==========================================
    // Signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    cdfs_pkg::cdfs_op_t op;
    logic cc;
    logic [31:0] mem;
    logic [31:0] result_o;
    cdfs_pkg::cdfs_flags_t flags_o;
    logic [31:0] q;
    int fail_count = 0;
    int n_checks = 0;

    always #5 clk_i = ~clk_i;

    cdfs_dec_model dec (.clk_i(clk_i), .op_o(op), .cc_o(cc), .mem_o(mem));

    cdfs_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_i(op), .condition_flag_i(cc),
        .mem_rdata_i(mem), .result_o(result_o), .flags_o(flags_o));

    // ==========================================
    // Tasks
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : ck

    task automatic fl(input logic [9:0] m, input logic [9:0] e);
        ck({22'h0, flags_o & m}, {22'h0, e});
    endtask : fl

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r);
        int i;
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_sel_i <= s;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1)
                break;
        end
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (i == 16)
        begin
            fail_count++;
            end_of_test();
        end
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(a, 1'b0, 32'h0000_0000, 4'hF, r);
        ck(r, exp);
    endtask : rd

    task automatic ld(input logic [2:0] r, input logic [31:0] m);
        dec.issue(cdfs_pkg::CDFS_LOAD, {1'b0, r, 8'h00}, 5'h04, m);
    endtask : ld

    // ==========================================
    // Watchdog
    initial
    begin
        #300000;
        fail_count++;
        end_of_test();
    end

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(cdfs_pkg::ADDR_STATUS, 32'h0000_0000);
        rd(cdfs_pkg::ADDR_RESULT, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        ld(3'h1, 32'h8001_F0A5);
        ld(3'h4, 32'h0000_4000);
        ld(3'h5, 32'h0000_0001);
        ld(3'h7, 32'h0000_8000);
        ld(3'h0, 32'h7FFF_FFFF);
        rd(cdfs_pkg::ADDR_DREG_BASE + 8'h04, 32'h8001_F0A5);
        dec.issue(cdfs_pkg::CDFS_LOAD, 12'h300, 5'h08, 32'hBEEF_1234);
        ck(result_o, 32'h0000_BEEF);
        dec.issue(cdfs_pkg::CDFS_EXT_HALF, 12'h210, 5'h00);
        ck(result_o, 32'h0000_F0A5);
        dec.issue(cdfs_pkg::CDFS_EXP, 12'h620, 5'h00);
        ck(result_o, 32'h0000_000F);
        dec.issue(cdfs_pkg::CDFS_EXT_HALF, 12'h210, 5'h02);
        ck(result_o, 32'hFFFF_F0A5);
        dec.issue(cdfs_pkg::CDFS_EXT_BYTE, 12'h210, 5'h00);
        ck(result_o, 32'h0000_00A5);
        dec.issue(cdfs_pkg::CDFS_EXT_BYTE, 12'h210, 5'h02);
        ck(result_o, 32'hFFFF_FFA5);
        dec.issue(cdfs_pkg::CDFS_EXP, 12'h620, 5'h00);
        ck(result_o, 32'h0000_0018);
        dec.issue(cdfs_pkg::CDFS_EXT_BYTE, 12'h640, 5'h00);
        fl(10'h001, 10'h001);
        dec.issue(cdfs_pkg::CDFS_ACC_HI_LD, 12'h010, 5'h00);
        fl(10'h001, 10'h001);
        dec.issue(cdfs_pkg::CDFS_ACC_LO_LD, 12'h040, 5'h00);
        fl(10'h001, 10'h000);
        dec.issue(cdfs_pkg::CDFS_ADD, 12'h605, 5'h00);
        ck(result_o, 32'h8000_0000);
        fl(10'h036, 10'h032);
        dec.issue(cdfs_pkg::CDFS_ADD, 12'h611, 5'h10);
        fl(10'h0C8, 10'h0C8);
        dec.issue(cdfs_pkg::CDFS_ADD, 12'h601, 5'h00);
        fl(10'h036, 10'h024);
        dec.issue(cdfs_pkg::CDFS_ADD, 12'h655, 5'h00);
        fl(10'h036, 10'h020);
        wb(cdfs_pkg::ADDR_STATUS, 1'b1, 32'h0000_0000, 4'hF, q);
        rd(cdfs_pkg::ADDR_STATUS, 32'h0000_0000);
        wb(cdfs_pkg::ADDR_RESULT, 1'b1, 32'h1234_5678, 4'hF, q);
        rd(cdfs_pkg::ADDR_RESULT, 32'h0000_0002);
        dec.issue(cdfs_pkg::CDFS_MOVCC, 12'h610, 5'h00, 32'h0000_0000, 1'b0, 1'b0);
        rd(cdfs_pkg::ADDR_DREG_BASE + 8'h18, 32'h0000_0002);
        dec.issue(cdfs_pkg::CDFS_MOVCC, 12'h610, 5'h00, 32'h0000_0000, 1'b0, 1'b1);
        rd(cdfs_pkg::ADDR_DREG_BASE + 8'h18, 32'h8001_F0A5);
        dec.issue(cdfs_pkg::CDFS_DIVSTEP, 12'h215, 5'h00);
        ck(result_o, 32'h0003_E14A);
        dec.issue(cdfs_pkg::CDFS_DIVSTEP, 12'h211, 5'h00);
        ck(result_o, 32'h0003_E14B);
        dec.issue(cdfs_pkg::CDFS_MUL, 12'h077, 5'h07);
        rd(cdfs_pkg::ADDR_ACC0_X, 32'h0000_0000);
        dec.issue(cdfs_pkg::CDFS_MUL, 12'h047, 5'h13);
        fl(10'h002, 10'h002);
        rd(cdfs_pkg::ADDR_ACC1_X, 32'h0000_00FF);
        dec.issue(cdfs_pkg::CDFS_ACC_PAIR, 12'h102, 5'h00);
        fl(10'h300, 10'h300);
        rd(cdfs_pkg::ADDR_DREG_BASE, 32'h8000_0000);
        rd(cdfs_pkg::ADDR_DREG_BASE + 8'h0C, 32'hE000_0000);
        dec.issue(cdfs_pkg::CDFS_MUL, 12'h074, 5'h00);
        dec.issue(cdfs_pkg::CDFS_ACC_TO_REG, 12'h500, 5'h00);
        ck(result_o, 32'h2000_0000);
        rd(cdfs_pkg::ADDR_DREG_BASE + 8'h10, 32'h2000_0000);
        fl(10'h200, 10'h200);
        wb(cdfs_pkg::ADDR_STATUS, 1'b1, 32'h0000_0000, 4'h2, q);
        #1;
        fl(10'h300, 10'h000);
        end_of_test();
    end
endmodule : test_core_data_format_and_status
